// *** rtl/fmc_pkg.sv ***
// Purpose: Shared constants for the fuse memory command control block
// Assumes: 8-bit register port, 16-entry fuse array of 8-bit words
// Notes:   Offsets are byte addresses on the plain register port
package fmc_pkg;

  // Register offsets
  localparam logic [7:0] OFF_CONFIG  = 8'h08; // Off-time, derating, dimming
  localparam logic [7:0] OFF_COMMAND = 8'h09; // Fuse command control
  localparam logic [7:0] OFF_DATA    = 8'h0a; // Fuse data
  localparam logic [7:0] OFF_STATUS  = 8'h0c; // Busy, lock, refused

  // Widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;

  // Configuration register fields
  localparam int CFG_TOFF_LSB  = 4;
  localparam int CFG_TOFF_MSB  = 7;
  localparam int CFG_DERATE    = 3;
  localparam int CFG_DIM_LSB   = 0;
  localparam int CFG_DIM_MSB   = 2;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Command register fields
  localparam int CMD_START     = 7;
  localparam int CMD_OP_LSB    = 5;
  localparam int CMD_OP_MSB    = 6;
  localparam int CMD_RSVD      = 4;
  localparam int CMD_ADDR_LSB  = 0;
  localparam int CMD_ADDR_MSB  = 3;

  // Status register fields
  localparam int STS_BUSY      = 0;
  localparam int STS_LOCK      = 1;
  localparam int STS_REFUSED   = 2;

  // Fuse lock location inside the fuse array
  localparam logic [3:0] LOCK_ADDR = 4'h0;
  localparam int         LOCK_BIT  = 7;

  // Fuse contents of a blank part
  localparam logic [7:0] FUSE_BLANK = 8'h00;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;

  // Operation duration in clock cycles
  localparam int OP_CYCLES_DEF = 4;

  // Fuse commands
  typedef enum logic [1:0] {
    CMD_POINT   = 2'h0,
    CMD_REFRESH = 2'h1,
    CMD_LOAD    = 2'h2,
    CMD_ZAP     = 2'h3
  } fmc_cmd_t;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_BUSY  = 3'h2,
    ST_APPLY = 3'h4
  } fmc_state_t;

endpackage : fmc_pkg

// *** rtl/fmc_fuse_if.sv ***
// Purpose: Carrier between the command sequencer and the fuse array
// Assumes: One clock domain
// Notes:   ctrl drives operations, mem answers with registered data
`timescale 1ns/10ps
`default_nettype none
interface fmc_fuse_if;
  import fmc_pkg::*;

  logic              op_valid;  // One-cycle operation pulse
  fmc_cmd_t          op_cmd;    // Operation to apply
  logic [ADDR_W-1:0] op_addr;   // Fuse location
  logic [DATA_W-1:0] op_data;   // Byte for load or zap
  logic [ADDR_W-1:0] rd_addr;   // Address for next read word
  logic [DATA_W-1:0] rd_data;   // Registered read word
  logic [DATA_W-1:0] lock_word; // Registered word holding lock

  modport ctrl (output op_valid, op_cmd, op_addr, op_data, rd_addr,
                input  rd_data, lock_word);
  modport mem  (input  op_valid, op_cmd, op_addr, op_data, rd_addr,
                output rd_data, lock_word);
endinterface : fmc_fuse_if
`default_nettype wire

// *** rtl/fmc_fuse_mem.sv ***
// Purpose: Fuse array with emulation shadow and registered read data
// Assumes: Zap only sets bits; shadow entry overrides fuse once loaded
// Notes:   Reset clears the array to model a blank part in simulation
`timescale 1ns/10ps
`default_nettype none
module fmc_fuse_mem
  import fmc_pkg::*;
#(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // Fuse access
  fmc_fuse_if.mem   fuse
);

  logic [DATA_W-1:0] fuse_q   [DEPTH];
  logic [DATA_W-1:0] shadow_q [DEPTH];
  logic [DEPTH-1:0]  shadow_vld_q;
  logic [DATA_W-1:0] view     [DEPTH];

  // Per-entry fuse, shadow and visible word
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    assign view[i] = shadow_vld_q[i] ? shadow_q[i] : fuse_q[i];

    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        fuse_q[i]       <= FUSE_BLANK;
        shadow_q[i]     <= FUSE_BLANK;
        shadow_vld_q[i] <= 1'b0;
      end else if (fuse.op_valid && fuse.op_addr == ADDR_W'(i)) begin
        if (fuse.op_cmd == CMD_ZAP) begin
          fuse_q[i] <= fuse_q[i] | fuse.op_data; // Blown fuses stay blown
        end
        if (fuse.op_cmd == CMD_LOAD) begin
          shadow_q[i]     <= fuse.op_data;
          shadow_vld_q[i] <= 1'b1;
        end
      end
    end
  end

  // Registered read ports
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fuse.rd_data   <= FUSE_BLANK;
      fuse.lock_word <= FUSE_BLANK;
    end else begin
      fuse.rd_data   <= view[fuse.rd_addr];
      fuse.lock_word <= view[LOCK_ADDR];
    end
  end

endmodule : fmc_fuse_mem
`default_nettype wire

// *** rtl/fmc_top.sv ***
// Purpose: Fuse memory command control and configuration register
// Assumes: Register port strobes are one cycle and never overlap
// Notes:   Command writes need the test pin; start bit self-clears
// Functional notes
// - Command writes accepted only with test pin high
// - Setting start bit executes selected command
// - Codes: point, refresh, load shadow, zap
// - Low nibble addresses the fuse location
// - Derating active while disable bit is zero
// - Config holds off-time, derate, dimming, reset zero
// - Data register feeds ops, reads addressed fuse
// - Lock bit blocks load and zap operations
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module fmc_top
  import fmc_pkg::*;
#(
  parameter int FUSE_DEPTH = 16,
  parameter int OP_CYCLES  = OP_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  // Test pin
  input  wire logic              test_mode_i,
  // Register port
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_we_i,
  input  wire logic              reg_re_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // Configuration outputs
  output logic      [3:0]        offtime_range_select_o,
  output logic                   power_derating_disable_o,
  output logic                   derating_active_o,
  output logic      [2:0]        dimming_frequency_factor_o,
  // Fuse status outputs
  output logic                   fuse_lock_bit_o,
  output logic                   fuse_busy_o
);

  // Timer wide enough to reach OP_CYCLES
  localparam int CNT_W = $clog2(OP_CYCLES + 1);

  // Register state
  logic [DATA_W-1:0] config_q;
  logic              start_q;
  fmc_cmd_t          cmd_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [DATA_W-1:0] data_q;
  logic              lock_q;
  logic              refused_q;
  logic              derate_q;

  // Sequencer state
  fmc_state_t        state_q;
  fmc_state_t        state_d;
  logic [CNT_W-1:0]  cnt_q;

  // Decoded accesses
  logic              wr_cfg;
  logic              wr_cmd;
  logic              wr_cmd_ok;
  logic              wr_data;
  logic              wr_sts;
  logic              trigger;
  logic              protected_op;
  logic              apply;
  logic [DATA_W-1:0] rd_mux;

  fmc_fuse_if fuse ();

  fmc_fuse_mem #(
    .DEPTH (FUSE_DEPTH)
  ) u_mem (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .fuse      (fuse.mem)
  );

  // Write decode; command writes are dropped while a command runs
  assign wr_cfg    = reg_we_i && reg_addr_i == OFF_CONFIG;
  assign wr_cmd    = reg_we_i && reg_addr_i == OFF_COMMAND;
  assign wr_data   = reg_we_i && reg_addr_i == OFF_DATA;
  assign wr_sts    = reg_we_i && reg_addr_i == OFF_STATUS;
  assign wr_cmd_ok = wr_cmd && test_mode_i && state_q == ST_IDLE;
  assign trigger   = wr_cmd_ok && reg_wdata_i[CMD_START];
  assign apply     = state_q == ST_APPLY;

  // Load and zap are blocked once the part is locked
  assign protected_op = lock_q && (cmd_q == CMD_LOAD || cmd_q == CMD_ZAP);

  // Configuration register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      config_q <= CFG_RESET;
    end else if (wr_cfg) begin
      config_q <= reg_wdata_i;
    end
  end

  // Configuration outputs, all straight from flops
  // Derating flag is the inverse of the disable bit, one cycle later
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      derate_q <= 1'b1;
    end else begin
      derate_q <= ~config_q[CFG_DERATE];
    end
  end

  assign offtime_range_select_o     = config_q[CFG_TOFF_MSB:CFG_TOFF_LSB];
  assign power_derating_disable_o   = config_q[CFG_DERATE];
  assign dimming_frequency_factor_o = config_q[CFG_DIM_MSB:CFG_DIM_LSB];
  assign derating_active_o          = derate_q;

  // Next fuse address, so the array read word tracks the register
  // The read port gets the next address, so a data read issued
  // right after a command write already sees the new location
  always_comb begin
    addr_d = addr_q;
    if (wr_cmd_ok) begin
      addr_d = reg_wdata_i[CMD_ADDR_MSB:CMD_ADDR_LSB];
    end else if (!test_mode_i && state_q == ST_IDLE) begin
      addr_d = '0;
    end
  end

  // Fuse address field; follows the decoded next address
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      addr_q <= '0;
    end else begin
      addr_q <= addr_d;
    end
  end

  // Command field; cleared while the test pin is low and idle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cmd_q <= CMD_POINT;
    end else if (wr_cmd_ok) begin
      // Reserved bit is not stored and reads back as zero
      cmd_q <= fmc_cmd_t'(reg_wdata_i[CMD_OP_MSB:CMD_OP_LSB]);
    end else if (!test_mode_i && state_q == ST_IDLE) begin
      cmd_q <= CMD_POINT;
    end
  end

  // Start bit: set by trigger, cleared at completion
  // Software polls it; it drops at the edge that ends the apply cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      start_q <= 1'b0;
    end else if (trigger) begin
      start_q <= 1'b1;
    end else if (apply) begin
      start_q <= 1'b0;
    end
  end

  // Data register for load and zap
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      data_q <= ZERO_BYTE;
    end else if (wr_data) begin
      data_q <= reg_wdata_i;
    end
  end

  // Sequencer next state
  // Busy for OP_CYCLES cycles, then one apply cycle that acts
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (trigger) begin
          state_d = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (cnt_q == CNT_W'(OP_CYCLES - 1)) begin
          state_d = ST_APPLY;
        end
      end
      ST_APPLY: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Operation timer; runs only while busy, so each command starts at zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
    end else if (state_q == ST_BUSY) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end else begin
      cnt_q <= '0;
    end
  end

  // Drive the fuse array
  // Point only moves the address; refused operations never reach it
  always_comb begin
    fuse.op_valid = apply && !protected_op && cmd_q != CMD_POINT;
    fuse.op_cmd   = cmd_q;
    fuse.op_addr  = addr_q;
    fuse.op_data  = data_q;
    fuse.rd_addr  = addr_d;
  end

  // Lock bit refreshed from the fuse array by a refresh command
  // Not loaded at reset; software must run a refresh first
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lock_q <= 1'b0;
    end else if (apply && cmd_q == CMD_REFRESH) begin
      lock_q <= fuse.lock_word[LOCK_BIT];
    end
  end

  // Sticky refused flag; a new refusal wins over a clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      refused_q <= 1'b0;
    end else if (apply && protected_op) begin
      refused_q <= 1'b1;
    end else if (wr_sts && reg_wdata_i[STS_REFUSED]) begin
      refused_q <= 1'b0;
    end
  end

  // Busy output; registered next state so it lines up with state_q
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fuse_busy_o <= 1'b0;
    end else begin
      fuse_busy_o <= state_d != ST_IDLE;
    end
  end

  // Lock output, one cycle behind the internal lock
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fuse_lock_bit_o <= 1'b0;
    end else begin
      fuse_lock_bit_o <= lock_q;
    end
  end

  // Read multiplexer
  // Data reads see the word latched a cycle ago; a read right at the
  // apply edge still returns the old word, so poll the start bit first
  always_comb begin
    rd_mux = ZERO_BYTE;
    unique case (reg_addr_i)
      OFF_CONFIG: begin
        rd_mux = config_q;
      end
      OFF_COMMAND: begin
        rd_mux[CMD_START]                 = start_q;
        rd_mux[CMD_OP_MSB:CMD_OP_LSB]     = cmd_q;
        rd_mux[CMD_ADDR_MSB:CMD_ADDR_LSB] = addr_q;
      end
      OFF_DATA: begin
        rd_mux = fuse.rd_data;
      end
      OFF_STATUS: begin
        rd_mux[STS_BUSY]    = state_q != ST_IDLE;
        rd_mux[STS_LOCK]    = lock_q;
        rd_mux[STS_REFUSED] = refused_q;
      end
      default: begin
        rd_mux = ZERO_BYTE;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= ZERO_BYTE;
    end else if (reg_re_i) begin
      reg_rdata_o <= rd_mux;
    end else begin
      reg_rdata_o <= ZERO_BYTE;
    end
  end

endmodule : fmc_top
`default_nettype wire

// *** test/fmc_top_sva.sv ***
// Purpose: Port-level checks for the fuse command control block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to fmc_top after the module
`timescale 1ns/10ps
`default_nettype none
module fmc_top_sva (
  // Clock, reset and test pin
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       test_mode_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_we_i,
  input wire logic       reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  // Block outputs
  input wire logic [3:0] offtime_range_select_o,
  input wire logic       power_derating_disable_o,
  input wire logic       derating_active_o,
  input wire logic [2:0] dimming_frequency_factor_o,
  input wire logic       fuse_lock_bit_o,
  input wire logic       fuse_busy_o
);
  // Decoded accesses and config image
  wire logic [7:0] cfg_w = {offtime_range_select_o, power_derating_disable_o, dimming_frequency_factor_o};
  wire logic       cmd_w = reg_we_i && reg_addr_i == 8'h09 && !fuse_busy_o;
  wire logic       unm_w = !(reg_addr_i inside {8'h08, 8'h09, 8'h0a, 8'h0c});
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_CFG_WRITE: assert property (reg_we_i && reg_addr_i == 8'h08 |=> cfg_w == $past(reg_wdata_i))
    else $error("config write not reflected");
  AST_CFG_READ: assert property (reg_re_i && reg_addr_i == 8'h08 |=> reg_rdata_o == $past(cfg_w))
    else $error("config read mismatch");
  AST_DERATE: assert property (##1 derating_active_o == !$past(power_derating_disable_o))
    else $error("derating state wrong");
  AST_CMD_REFUSED: assert property (cmd_w && !test_mode_i |=> !fuse_busy_o)
    else $error("command taken with test pin low");
  AST_CMD_START: assert property (cmd_w && test_mode_i && reg_wdata_i[7] |=> fuse_busy_o)
    else $error("start did not launch command");
  AST_BUSY_END: assert property ($rose(fuse_busy_o) |-> ##[1:64] !fuse_busy_o)
    else $error("command never completed");
  AST_READ_IDLE: assert property (!reg_re_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  AST_UNMAPPED: assert property (reg_re_i && unm_w |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_LOCK_SRC: assert property ($changed(fuse_lock_bit_o) |-> $past(fuse_busy_o, 2))
    else $error("lock changed outside command");
  // Main scenarios
  COV_START: cover property (cmd_w && test_mode_i && reg_wdata_i[7]);
  COV_REFUSE: cover property (cmd_w && !test_mode_i);
  COV_LOCK: cover property ($rose(fuse_lock_bit_o));
endmodule : fmc_top_sva
bind fmc_top fmc_top_sva u_fmc_top_sva (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .test_mode_i(test_mode_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
  .offtime_range_select_o(offtime_range_select_o), .power_derating_disable_o(power_derating_disable_o),
  .derating_active_o(derating_active_o), .dimming_frequency_factor_o(dimming_frequency_factor_o),
  .fuse_lock_bit_o(fuse_lock_bit_o), .fuse_busy_o(fuse_busy_o));
`default_nettype wire

// *** test/fuse_memory_command_control_tb_top.sv ***
// Purpose: Self-checking bench for the fuse command control block
// Assumes: Short command time, blank fuse array after reset
// Notes:   Random data from a fixed-seed xorshift
`timescale 1ns/10ps
`default_nettype none
module fuse_memory_command_control_tb_top;
  import fmc_pkg::*;
  logic       clk_i = 1'b0, sys_rst_i = 1'b1, test_mode_i = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, rd_q, v;
  logic [3:0] toff, a;
  logic [2:0] dim;
  logic       dis, act, lock, busy;
  logic [31:0] seed = 32'he459a15f;
  logic [7:0] vis [16] = '{default: 8'h00};
  int         miscompares = 0, compares = 0;
  // Clock
  always #2.5 clk_i = ~clk_i;
  fmc_top #(.OP_CYCLES(1)) u_fmc_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .test_mode_i(test_mode_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .offtime_range_select_o(toff), .power_derating_disable_o(dis),
    .derating_active_o(act), .dimming_frequency_factor_o(dim), .fuse_lock_bit_o(lock), .fuse_busy_o(busy));
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= ad;
    reg_wdata_i <= d;
    reg_we_i    <= 1'b1;
    @(posedge clk_i);
    reg_we_i    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    @(posedge clk_i);
    reg_addr_i <= ad;
    reg_re_i   <= 1'b1;
    @(posedge clk_i);
    reg_re_i   <= 1'b0;
    #1 rd_q = reg_rdata_o;
  endtask : rd
  // Stage data, launch, poll start bit until it drops
  task automatic run(input logic [1:0] op, input logic [3:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    wr(OFF_DATA, d);
    wr(OFF_COMMAND, {1'b1, op, 1'b0, ad});
    do begin
      rd(OFF_COMMAND);
      n++;
    end while (rd_q[7] !== 1'b0 && n < 20);
    chk(rd_q & 8'h8f, {4'h0, ad});
  endtask : run
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // Watchdog
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    #1 chk({toff, dis, dim}, CFG_RESET);
    chk({7'h00, act}, 8'h01);
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h08 : xs();
      wr(OFF_CONFIG, v);
      rd(OFF_CONFIG);
      chk(rd_q, v);
      chk({toff, dis, dim}, v);
      chk({7'h00, act}, {7'h00, !v[3]});
    end
    $display("test config done");
    wr(OFF_COMMAND, 8'he5);
    rd(OFF_COMMAND);
    chk(rd_q, 8'h00);
    chk({7'h00, busy}, 8'h00);
    rd(8'h3f);
    chk(rd_q, 8'h00);
    $display("test refused done");
    // Test pin raised on a clock edge after the refused command write, before the first accepted one
    @(posedge clk_i);
    test_mode_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      a = 4'(xs() % 14 + 1);
      v = xs();
      run(CMD_ZAP, a, v);
      vis[a] |= v;
      rd(OFF_DATA);
      chk(rd_q, vis[a]);
    end
    for (int k = 1; k < 15; k++) begin
      run(CMD_POINT, 4'(k), 8'h00);
      rd(OFF_DATA);
      chk(rd_q, vis[k]);
    end
    v = xs();
    run(CMD_LOAD, 4'hf, v);
    rd(OFF_DATA);
    chk(rd_q, v);
    // Command written without start bit must not act
    wr(OFF_DATA, 8'hff);
    wr(OFF_COMMAND, {1'b0, CMD_ZAP, 1'b0, 4'h3});
    rd(OFF_COMMAND);
    chk(rd_q, {1'b0, CMD_ZAP, 1'b0, 4'h3});
    rd(OFF_DATA);
    chk(rd_q, vis[3]);
    // Busy status while a command runs, start clear afterwards
    wr(OFF_COMMAND, {1'b1, CMD_POINT, 1'b0, 4'h1});
    rd(OFF_STATUS);
    chk(rd_q & 8'h01, 8'h01);
    rd(OFF_COMMAND);
    chk(rd_q, 8'h01);
    $display("test operations done");
    run(CMD_ZAP, 4'h0, 8'h80);
    chk({7'h00, lock}, 8'h00);
    run(CMD_REFRESH, 4'h0, 8'h00);
    chk({7'h00, lock}, 8'h01);
    run(CMD_ZAP, 4'h1, 8'hff);
    rd(OFF_DATA);
    chk(rd_q, vis[1]);
    rd(OFF_STATUS);
    chk(rd_q, 8'h06);
    wr(OFF_STATUS, 8'h04);
    rd(OFF_STATUS);
    chk(rd_q, 8'h02);
    run(CMD_LOAD, 4'h2, 8'h5a);
    rd(OFF_DATA);
    chk(rd_q, vis[2]);
    rd(OFF_STATUS);
    chk(rd_q, 8'h06);
    $display("test lock done");
    // Reset in mid-run clears config, lock and refusal
    wr(OFF_CONFIG, 8'hff);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    #1 chk({toff, dis, dim}, CFG_RESET);
    chk({7'h00, act}, 8'h01);
    chk({7'h00, lock}, 8'h00);
    rd(OFF_STATUS);
    chk(rd_q, 8'h00);
    rd(OFF_COMMAND);
    chk(rd_q, 8'h00);
    $display("test reset done");
    stop_test();
  end
endmodule : fuse_memory_command_control_tb_top
`default_nettype wire
